/* File: src/ocm_top.sv */
// Clock source control with fail-safe monitor and keyed register writes
// Operation
// - Lock status follows PLL lock input
// - Current group 01 selects fast RC
// - Four-bit signed trim over bits 15:14,11:10
// - Low-power RC enabled at power-on
// - After timer, keep LOW_POWER_INTERNAL_RC only if needed
// - Monitor on keeps LOW_POWER_INTERNAL_RC except Sleep
// - Failure raises trap, falls back fast RC
// - Failure: load fast RC, set flag, clear go
// - Watchdog unaffected by clock failure
// - Slow start after timer traps too
// - Switch only between four groups
// - Current group read-only, new group writable
// - Reset loads both groups from config
// - Clock-fail flag is read-only status
// - Go clears when transition completes, clear aborts
// - Config 1x disables switching and monitor
// - Switching off: config selects directly
// - Low byte needs keys 46 then 57
// - High byte needs keys 78 then 9A
// - Lock status at bit 5
// - Group 00 is the secondary crystal
`timescale 1ns/100ps
`include "ocm_defs.svh"
module ocm_top #(
	parameter int SWITCH_CYC = `OCM_SWITCH_CYC
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// AXI4-Lite write
	input  wire logic [11:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [11:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Configuration straps (static, same domain)
	input  wire ocm_pkg::ocm_grp_t group_select_cfg,
	input  wire logic [3:0]        primary_select_cfg,
	input  wire logic [1:0]        switch_monitor_cfg,
	input  wire logic              watchdog_cfg_en,
	// Oscillator status pins
	input  wire logic              pll_lock_pin,
	input  wire logic              osc_fail_pin,
	input  wire logic              osc_started_pin,
	input  wire logic              power_up_timer_done,
	input  wire logic              sleep_mode,
	// Oscillator control outputs
	output ocm_pkg::ocm_grp_t      clk_group_sel,
	output logic [3:0]             primary_sel,
	output logic [3:0]             fast_rc_trim,
	output logic                   low_power_internal_rc_enable,
	output logic                   watchdog_run,
	output logic                   clock_fail_trap
);
	import ocm_pkg::*;

	// ==========================================================================
	// Pin synchronisers
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
		end else begin
			sync1_r <= {pll_lock_pin, osc_fail_pin, osc_started_pin,
				power_up_timer_done};
			sync2_r <= sync1_r;
		end
	end
	wire lock_s    = sync2_r[3];
	wire fail_s    = sync2_r[2];
	wire started_s = sync2_r[1];
	wire power_up_timer_s    = sync2_r[0];

	// ==========================================================================
	// Registers
	ocm_grp_t   cur_r;
	ocm_grp_t   new_r;
	logic [3:0] trim_r;
	logic       fail_r;
	logic       go_r;
	logic       lock_r;
	logic       init_r;
	logic       power_up_timer_seen_r;
	logic       trap_r;
	ocm_key_t   key_lo_r;
	ocm_key_t   key_hi_r;
	ocm_sw_t    sw_r;
	logic [15:0] sw_cnt_r;

	// Monitor and switching enable
	wire switch_en  = ~switch_monitor_cfg[1];
	wire monitor_en = (switch_monitor_cfg == 2'h0);

	// ==========================================================================
	// AXI4-Lite write channel
	logic        aw_held_r;
	logic        w_held_r;
	logic [11:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take  = s_axi_wvalid & s_axi_wready;
	wire wr_go   = aw_held_r & w_held_r & ~s_axi_bvalid;
	wire wr_ctrl = wr_go & (awaddr_r[11:2] == `OCM_CTRL_OFFS >> 2);
	wire wr_known = (awaddr_r[11:2] == `OCM_CTRL_OFFS >> 2) |
		(awaddr_r[11:2] == `OCM_CFG_OFFS >> 2) |
		(awaddr_r[11:2] == `OCM_STAT_OFFS >> 2);
	wire [7:0] wlo = wdata_r[7:0];
	wire [7:0] whi = wdata_r[15:8];
	wire lo_wr = wr_ctrl & wstrb_r[0];
	wire hi_wr = wr_ctrl & wstrb_r[1];
	// Protected writes land only while the matching key is open
	wire lo_ok = lo_wr & (key_lo_r == OCM_KEY_OPEN);
	wire hi_ok = hi_wr & (key_hi_r == OCM_KEY_OPEN);

	always_ff @(posedge clk) begin
		if (rst) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awaddr_r  <= 12'h000;
			wdata_r   <= 32'h00000000;
			wstrb_r   <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else begin
			if (aw_take) begin
				aw_held_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (w_take) begin
				w_held_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held_r    <= 1'b0;
				w_held_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_known ? 2'h0 : 2'h2;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;

	// ==========================================================================
	// Unlock key sequencers: one bus write is one instruction cycle
	function automatic ocm_key_t key_step(input ocm_key_t st,
		input logic wr, input logic [7:0] d,
		input logic [7:0] k1, input logic [7:0] k2);
		ocm_key_t nx;
		nx = st;
		if (wr) begin
			case (st)
				OCM_KEY_IDLE: nx = (d == k1) ? OCM_KEY_ONE : OCM_KEY_IDLE;
				OCM_KEY_ONE:  nx = (d == k2) ? OCM_KEY_OPEN :
					((d == k1) ? OCM_KEY_ONE : OCM_KEY_IDLE);
				default:      nx = OCM_KEY_IDLE;
			endcase
		end else if (wr_go) begin
			// Any other write breaks the chain; the open window is one write
			nx = OCM_KEY_IDLE;
		end
		return nx;
	endfunction : key_step

	wire ocm_key_t key_lo_nxt = key_step(key_lo_r, lo_wr, wlo,
		`OCM_KEY_LO1, `OCM_KEY_LO2);
	wire ocm_key_t key_hi_nxt = key_step(key_hi_r, hi_wr, whi,
		`OCM_KEY_HI1, `OCM_KEY_HI2);

	always_ff @(posedge clk) begin
		if (rst) begin
			key_lo_r <= OCM_KEY_IDLE;
			key_hi_r <= OCM_KEY_IDLE;
		end else begin
			key_lo_r <= key_lo_nxt;
			key_hi_r <= key_hi_nxt;
		end
	end

	// ==========================================================================
	// Failure detection and switch sequencing
	wire slow_start = power_up_timer_s & ~power_up_timer_seen_r & ~started_s;
	wire fail_evt   = monitor_en & init_r & (fail_s | slow_start);
	wire go_set     = lo_ok & wlo[`OCM_GO_BIT] & switch_en;
	wire go_clr_sw  = lo_ok & ~wlo[`OCM_GO_BIT];
	wire sw_done    = (sw_r == OCM_SW_BUSY) && (sw_cnt_r == 16'h0000);

	always_ff @(posedge clk) begin
		if (rst) begin
			cur_r       <= OCM_GRP_FRC;
			new_r       <= OCM_GRP_FRC;
			init_r      <= 1'b0;
			trim_r      <= 4'h0;
			fail_r      <= 1'b0;
			go_r        <= 1'b0;
			lock_r      <= 1'b0;
			power_up_timer_seen_r <= 1'b0;
			trap_r      <= 1'b0;
			sw_r        <= OCM_SW_IDLE;
			sw_cnt_r    <= 16'h0000;
		end else begin
			lock_r      <= lock_s;
			power_up_timer_seen_r <= power_up_timer_s;
			trap_r      <= fail_evt;
			init_r      <= 1'b1;
			if (!init_r) begin
				cur_r <= group_select_cfg;
				new_r <= group_select_cfg;
			end else if (fail_evt) begin
				cur_r <= OCM_GRP_FRC;
				fail_r <= 1'b1;
				go_r   <= 1'b0;
				sw_r   <= OCM_SW_IDLE;
			end else begin
				if (!switch_en)
					cur_r <= group_select_cfg;
				if (hi_ok) begin
					new_r  <= ocm_grp_t'(whi[1:0]);
					trim_r <= {whi[7:6], whi[3:2]};
				end
				case (sw_r)
					OCM_SW_IDLE: begin
						if (go_set) begin
							go_r     <= 1'b1;
							sw_r     <= OCM_SW_BUSY;
							sw_cnt_r <= 16'(SWITCH_CYC - 1);
						end
					end
					OCM_SW_BUSY: begin
						if (go_clr_sw) begin
							go_r <= 1'b0;
							sw_r <= OCM_SW_IDLE;
						end else if (sw_done) begin
							cur_r <= new_r;
							go_r  <= 1'b0;
							sw_r  <= OCM_SW_IDLE;
						end else begin
							sw_cnt_r <= sw_cnt_r - 16'h0001;
						end
					end
					default: sw_r <= OCM_SW_IDLE;
				endcase
			end
		end
	end

	// ==========================================================================
	// Read channel
	wire [15:0] ctrl_rd = {trim_r[3:2], cur_r, trim_r[1:0], new_r,
		2'h0, lock_r, 1'b0, fail_r, 2'h0, go_r};
	wire [31:0] cfg_rd  = {23'h0, watchdog_cfg_en, switch_monitor_cfg,
		primary_select_cfg, group_select_cfg};
	wire [31:0] stat_rd = {28'h0, low_power_internal_rc_enable, power_up_timer_s, started_s, lock_r};
	wire [11:0] ra = s_axi_araddr;
	wire rd_ctrl = (ra[11:2] == `OCM_CTRL_OFFS >> 2);
	wire rd_cfg  = (ra[11:2] == `OCM_CFG_OFFS >> 2);
	wire rd_stat = (ra[11:2] == `OCM_STAT_OFFS >> 2);
	wire [31:0] rd_val = rd_ctrl ? {16'h0, ctrl_rd} :
		rd_cfg ? cfg_rd : rd_stat ? stat_rd : 32'h00000000;
	wire rd_hit = rd_ctrl | rd_cfg | rd_stat;

	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= 2'h0;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_val;
			s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	assign s_axi_arready = ~s_axi_rvalid;

	// ==========================================================================
	// Oscillator control outputs
	wire low_power_internal_rc_need = (monitor_en & ~sleep_mode) | watchdog_cfg_en |
		(cur_r == OCM_GRP_LOW_POWER_INTERNAL_RC);
	wire low_power_internal_rc_nxt  = ~power_up_timer_s | low_power_internal_rc_need;

	always_ff @(posedge clk) begin
		if (rst) begin
			clk_group_sel   <= OCM_GRP_FRC;
			primary_sel     <= 4'h0;
			fast_rc_trim    <= 4'h0;
			low_power_internal_rc_enable     <= 1'b1;
			watchdog_run    <= 1'b0;
			clock_fail_trap <= 1'b0;
		end else begin
			clk_group_sel   <= cur_r;
			primary_sel     <= primary_select_cfg;
			fast_rc_trim    <= trim_r;
			low_power_internal_rc_enable     <= low_power_internal_rc_nxt;
			// Watchdog sees only its own enable, never the failure
			watchdog_run    <= watchdog_cfg_en;
			clock_fail_trap <= trap_r;
		end
	end

	// ==========================================================================
	// Checks
	initial begin
		if (SWITCH_CYC < 1 || SWITCH_CYC > 65535)
			$error("SWITCH_CYC out of range");
	end

	sequence s_fail;
		fail_evt;
	endsequence

	chk_fail_group: assert property (@(posedge clk) disable iff (rst)
		s_fail |=> cur_r == OCM_GRP_FRC && fail_r && !go_r)
		else $error("failure did not load fast RC");
	chk_fail_trap: assert property (@(posedge clk) disable iff (rst)
		s_fail |=> ##1 clock_fail_trap)
		else $error("trap not raised");
	chk_flag_sticky: assert property (@(posedge clk) disable iff (rst)
		fail_r |=> fail_r)
		else $error("fail flag dropped");
	chk_lock_follow: assert property (@(posedge clk) disable iff (rst)
		lock_s |=> lock_r)
		else $error("lock not mirrored");
	chk_key_lo: assert property (@(posedge clk) disable iff (rst)
		key_lo_r == OCM_KEY_OPEN && !$past(key_lo_r == OCM_KEY_OPEN)
		|-> $past(lo_wr) && $past(wlo) == `OCM_KEY_LO2)
		else $error("low byte write without keys");
	chk_key_hi: assert property (@(posedge clk) disable iff (rst)
		key_hi_r == OCM_KEY_OPEN && !$past(key_hi_r == OCM_KEY_OPEN)
		|-> $past(hi_wr) && $past(whi) == `OCM_KEY_HI2)
		else $error("high byte write without keys");
	chk_key_break: assert property (@(posedge clk) disable iff (rst)
		key_lo_r == OCM_KEY_OPEN && wr_go |=> key_lo_r == OCM_KEY_IDLE)
		else $error("unlock window too long");
	chk_cfg_direct: assert property (@(posedge clk) disable iff (rst)
		init_r && !switch_en |=> ##1 clk_group_sel == $past(group_select_cfg, 2))
		else $error("config does not select directly");
	chk_low_power_internal_rc_mon: assert property (@(posedge clk) disable iff (rst)
		monitor_en && !sleep_mode |=> low_power_internal_rc_enable)
		else $error("low_power_internal_rc off with monitor on");
	chk_no_switch: assert property (@(posedge clk) disable iff (rst)
		!switch_en |-> !go_set)
		else $error("switch started while disabled");
endmodule : ocm_top

/* File: inc/ocm_defs.svh */
// Offsets, field positions, unlock keys and timing counts for the clock monitor
`ifndef OCM_DEFS_SVH
`define OCM_DEFS_SVH
// ==========================================================================
// Register map
`define OCM_CTRL_OFFS      12'h000
`define OCM_CFG_OFFS       12'h004
`define OCM_STAT_OFFS      12'h008
// ==========================================================================
// Control register fields
`define OCM_TRIM_HI_MSB    15
`define OCM_TRIM_HI_LSB    14
`define OCM_CUR_MSB        13
`define OCM_CUR_LSB        12
`define OCM_TRIM_LO_MSB    11
`define OCM_TRIM_LO_LSB    10
`define OCM_NEW_MSB        9
`define OCM_NEW_LSB        8
`define OCM_LOCK_BIT       5
`define OCM_FAIL_BIT       3
`define OCM_GO_BIT         0
// ==========================================================================
// Unlock keys
`define OCM_KEY_LO1        8'h46
`define OCM_KEY_LO2        8'h57
`define OCM_KEY_HI1        8'h78
`define OCM_KEY_HI2        8'h9A
// ==========================================================================
// Timing
`define OCM_SWITCH_NS      500
`define OCM_CLK_NS         50
`define OCM_SWITCH_CYC     ((`OCM_SWITCH_NS + `OCM_CLK_NS - 1) / `OCM_CLK_NS)
`endif

/* File: inc/ocm_pkg.sv */
// Types shared by the clock monitor
package ocm_pkg;
	// ==========================================================================
	// Oscillator groups
	typedef enum logic [1:0] {
		OCM_GRP_SEC  = 2'h0,
		OCM_GRP_FRC  = 2'h1,
		OCM_GRP_LOW_POWER_INTERNAL_RC = 2'h2,
		OCM_GRP_PRI  = 2'h3
	} ocm_grp_t;
	// ==========================================================================
	// Unlock key progress
	typedef enum logic [2:0] {
		OCM_KEY_IDLE = 3'h1,
		OCM_KEY_ONE  = 3'h2,
		OCM_KEY_OPEN = 3'h4
	} ocm_key_t;
	// ==========================================================================
	// Switch sequencer
	typedef enum logic [1:0] {
		OCM_SW_IDLE = 2'h1,
		OCM_SW_BUSY = 2'h2
	} ocm_sw_t;
endpackage : ocm_pkg

/* File: dv/ocm_top_tb_top.sv */
// Self-checking bench for the clock source control block
`timescale 1ns/100ps
module ocm_top_tb_top;
	import ocm_pkg::*;
	// ==========================================================================
	// Signals
	localparam int SW = 40;
	logic        clk = 1'h0, rst = 1'h1;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb = 4'h0, primary_select_cfg, primary_sel;
	logic [3:0]  fast_rc_trim, t;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, switch_monitor_cfg = 2'h2;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
	logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, low_power_internal_rc_enable, watchdog_run, clock_fail_trap;
	logic        watchdog_cfg_en = 1'h0, pll_lock_pin = 1'h0, sleep_mode = 1'h0;
	logic        osc_fail_pin = 1'h0, osc_started_pin = 1'h1;
	logic        power_up_timer_done = 1'h0;
	ocm_grp_t    group_select_cfg = OCM_GRP_FRC, clk_group_sel, g;
	int          bad_count = 0, samples_checked = 0, i;

	always #25 clk = ~clk;

	ocm_top #(.SWITCH_CYC(SW)) uut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .group_select_cfg, .primary_select_cfg,
		.switch_monitor_cfg, .watchdog_cfg_en, .pll_lock_pin, .osc_fail_pin,
		.osc_started_pin, .power_up_timer_done, .sleep_mode, .clk_group_sel,
		.primary_sel, .fast_rc_trim, .low_power_internal_rc_enable, .watchdog_run,
		.clock_fail_trap);

	// ==========================================================================
	// Helpers
	task automatic complete_run;
		if (bad_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// Bready and rready stay high, so each wait ends on the answer edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		repeat (50) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		rsp = s_axi_bresp;
	endtask : wr

	task automatic rdr(input logic [11:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		repeat (50) begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask : rdr

	// Two key writes, then the payload, all on one byte lane
	task automatic keyed(input logic hi, input logic [7:0] v, k1, k2);
		logic [3:0] s;
		s = hi ? 4'h2 : 4'h1;
		wr(12'h000, {16'h0000, k1, k1}, s);
		wr(12'h000, {16'h0000, k2, k2}, s);
		wr(12'h000, {16'h0000, v, v}, s);
		// Let the registered outputs settle past the answer edge
		tick(1);
	endtask : keyed

	task automatic do_rst(input ocm_grp_t gs);
		rst <= 1'h1;
		group_select_cfg <= gs;
		tick(2);
		check(low_power_internal_rc_enable, 1'h1);
		rst <= 1'h0;
		tick(3);
		check(clk_group_sel, gs);
		check(primary_sel, primary_select_cfg);
		rdr(12'h000);
		check({rd[13:12], rd[9:8]}, {gs, gs});
	endtask : do_rst

	task automatic see_trap;
		logic hit;
		hit = 1'h0;
		repeat (10) begin
			@(posedge clk);
			hit |= clock_fail_trap;
		end
		check(hit, 1'h1);
	endtask : see_trap

	function automatic logic exp_low_power_internal_rc(input ocm_grp_t gs);
		return !power_up_timer_done || switch_monitor_cfg == 2'h0
			|| watchdog_cfg_en || gs == OCM_GRP_LOW_POWER_INTERNAL_RC;
	endfunction : exp_low_power_internal_rc

	// ==========================================================================
	// Watchdog and main sequence
	initial begin
		tick(20000);
		bad_count++;
		complete_run;
	end

	initial begin
		void'($urandom(33041));
		primary_select_cfg = 4'($urandom);
		// Monitor and switching off: every group code out of reset
		for (i = 0; i < 4; i++) begin
			g = ocm_grp_t'(i[1:0]);
			power_up_timer_done <= 1'h0;
			do_rst(g);
			power_up_timer_done <= 1'h1;
			tick(5);
			check(low_power_internal_rc_enable, exp_low_power_internal_rc(g));
			watchdog_cfg_en <= 1'h1;
			tick(5);
			check(low_power_internal_rc_enable, exp_low_power_internal_rc(g));
			check(watchdog_run, 1'h1);
			watchdog_cfg_en <= 1'h0;
		end
		pll_lock_pin <= 1'h1;
		tick(5);
		rdr(12'h000);
		check(rd[5], 1'h1);
		pll_lock_pin <= 1'h0;
		tick(5);
		rdr(12'h000);
		check(rd[5], 1'h0);
		// Trim corners then random codes; current bits written as 00
		for (i = 0; i < 6; i++) begin
			t = (i < 3) ? 4'(12'h087 >> (4 * i)) : 4'($urandom);
			keyed(1'h1, {t[3:2], 2'h0, t[1:0], 2'h3}, 8'h78, 8'h9A);
			check(fast_rc_trim, t);
			rdr(12'h000);
			check(rd[15:8], {t[3:2], 2'h3, t[1:0], 2'h3});
		end
		wr(12'h000, 32'h0000_0000, 4'h2);
		tick(1);
		check(fast_rc_trim, t);
		keyed(1'h1, 8'h03, 8'h9A, 8'h78);
		check(fast_rc_trim, t);
		keyed(1'h1, 8'h01, 8'h78, 8'h9A);
		keyed(1'h0, 8'h01, 8'h46, 8'h57);
		osc_fail_pin <= 1'h1;
		tick(SW + 10);
		check(clk_group_sel, OCM_GRP_PRI);
		osc_fail_pin <= 1'h0;
		rdr(12'h00C);
		check({rsp, rd}, {2'h2, 32'h0});
		// Switching only: start, complete, abort, refused starts
		switch_monitor_cfg <= 2'h1;
		do_rst(OCM_GRP_FRC);
		keyed(1'h1, 8'h03, 8'h78, 8'h9A);
		keyed(1'h0, 8'h01, 8'h46, 8'h57);
		rdr(12'h000);
		check(rd[0], 1'h1);
		check(clk_group_sel, OCM_GRP_FRC);
		tick(SW + 10);
		check(clk_group_sel, OCM_GRP_PRI);
		keyed(1'h1, 8'h02, 8'h78, 8'h9A);
		keyed(1'h0, 8'h01, 8'h46, 8'h57);
		keyed(1'h0, 8'h00, 8'h46, 8'h57);
		tick(SW + 10);
		check(clk_group_sel, OCM_GRP_PRI);
		wr(12'h000, 32'h0000_0101, 4'h1);
		keyed(1'h0, 8'h01, 8'h57, 8'h46);
		tick(SW + 10);
		check(clk_group_sel, OCM_GRP_PRI);
		// Monitor on: oscillator failure
		switch_monitor_cfg <= 2'h0;
		do_rst(OCM_GRP_PRI);
		watchdog_cfg_en <= 1'($urandom);
		osc_fail_pin <= 1'h1;
		see_trap;
		check(clk_group_sel, OCM_GRP_FRC);
		rdr(12'h000);
		check({rd[13:12], rd[3], rd[0]}, 4'h6);
		check(watchdog_run, watchdog_cfg_en);
		check(low_power_internal_rc_enable, 1'h1);
		osc_fail_pin <= 1'h0;
		keyed(1'h0, 8'h00, 8'h46, 8'h57);
		rdr(12'h000);
		check(rd[3], 1'h1);
		// Timer expiry before a slow source has started
		osc_started_pin <= 1'h0;
		power_up_timer_done <= 1'h0;
		do_rst(OCM_GRP_SEC);
		power_up_timer_done <= 1'h1;
		see_trap;
		check(clk_group_sel, OCM_GRP_FRC);
		complete_run;
	end
endmodule : ocm_top_tb_top
